// ### rtl/qds_core.sv
// quad driver serial control: shift port, output latch, fault capture
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Operation
// - channel on when latched bit or direct input high.
// - direct input n drives channel n only.
// - bits 3..0 set channels 3..0; bits 7..4 ignored; msb first.
// - port active only while chip select low.
// - select fall captures faults seen since last select rise.
// - fault bits shift out while command shifts in.
// - select rise loads last four shifted bits into latch.
// - supply short and overcurrent recorded only while channel on.
// - open load and ground short recorded only while channel off.
// - sixteen-bit frame applies its last four bits on select rise.
// - next sixteen-bit frame returns faults then previous first byte.
// - undriven select reads high; data and direct inputs read low.
// - shifting happens only while select low, allowing daisy chains.
// - chained devices all switch at the same select rise.
// - shared-line devices accept input only under own select.
// - serial input sampled on shift clock rising edge.
// - serial output changes on shift clock falling edge, bit 7 first.
// - serial output released while select high.
// - fault bits 0..3 report channels 0..3; one means fault.
module qds_core
  import qds_pkg::*;
#(
  parameter int CHANNELS = QDS_CHANNELS
) (
  input wire logic clk,
  input wire logic rstn,
  input wire qds_link_in_t link_in,
  input wire logic [CHANNELS-1:0] direct_drive,
  input wire logic [CHANNELS-1:0] direct_drive_en,
  input wire logic sdi_en,
  input wire logic chip_sel_en,
  input wire qds_detect_t detect,
  output logic sdo_out,
  output logic sdo_oe_n,
  output logic [CHANNELS-1:0] driver_chan,
  output logic [CHANNELS-1:0] cmd_latch,
  output logic [CHANNELS-1:0] fault_sticky,
  output logic frame_active
);

  ////////////////////////////////////////////////////////////////////////////////
  // pin conditioning: undriven select, data and direct pins take their pull level; sclk has none
  logic sclk_pin;
  logic sdi_pin;
  logic csn_pin;
  logic [CHANNELS-1:0] dd_pin;

  // pull levels
  // an enable held low stands for a floating pin
  always_comb begin
    sclk_pin = link_in.sclk;
    sdi_pin = sdi_en & link_in.sdi;
    csn_pin = ~chip_sel_en | link_in.chip_sel_n;
    dd_pin = direct_drive & direct_drive_en;
  end

  // two-flop synchronisers; stage one is read only by stage two
  // trade-off: about three clocks of latency, small against the shortest shift period
  qds_link_in_t s1_q;
  qds_link_in_t s2_q;
  qds_link_in_t s3_q;
  logic [CHANNELS-1:0] dd2_q;

  // reset to the idle pin levels so no false select or clock edge follows release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_q.sclk <= 1'b0;
      s1_q.sdi <= 1'b0;
      s1_q.chip_sel_n <= 1'b1;
    end else begin
      s1_q <= {sclk_pin, sdi_pin, csn_pin};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s2_q.sclk <= 1'b0;
      s2_q.sdi <= 1'b0;
      s2_q.chip_sel_n <= 1'b1;
    end else begin
      s2_q <= s1_q;
    end
  end

  // third stage keeps history for the edge detectors only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s3_q.sclk <= 1'b0;
      s3_q.sdi <= 1'b0;
      s3_q.chip_sel_n <= 1'b1;
    end else begin
      s3_q <= s2_q;
    end
  end

  genvar d;
  generate
    for (d = 0; d < CHANNELS; d++) begin : g_dd_sync
      logic dd1_q;
      logic dd2_bit_q;

      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          dd1_q <= 1'b0;
        end else begin
          dd1_q <= dd_pin[d];
        end
      end

      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          dd2_bit_q <= 1'b0;
        end else begin
          dd2_bit_q <= dd1_q;
        end
      end

      assign dd2_q[d] = dd2_bit_q;
    end
  endgenerate

  logic sclk_s;
  logic sdi_s;
  logic csn_s;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;

  always_comb begin
    sclk_s = s2_q.sclk;
    sdi_s = s2_q.sdi;
    csn_s = s2_q.chip_sel_n;
    sclk_rise = sclk_s & ~s3_q.sclk;
    sclk_fall = ~sclk_s & s3_q.sclk;
    cs_fall = ~csn_s & s3_q.chip_sel_n;
    cs_rise = csn_s & ~s3_q.chip_sel_n;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // frame state
  qds_state_t state_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= QDS_IDLE;
    end else begin
      case (state_q)
        QDS_IDLE: begin
          if (cs_fall) begin
            state_q <= QDS_FRAME;
          end
        end
        QDS_FRAME: begin
          if (cs_rise) begin
            state_q <= QDS_IDLE;
          end
        end
        default: begin
          state_q <= QDS_IDLE;
        end
      endcase
    end
  end

  assign frame_active = (state_q == QDS_FRAME);

  ////////////////////////////////////////////////////////////////////////////////
  // frame events; edges seen in the wrong state are dropped
  logic capture_evt;
  logic apply_evt;
  logic shift_evt;
  logic out_evt;

  always_comb begin
    capture_evt = cs_fall && (state_q == QDS_IDLE);
    apply_evt = cs_rise && (state_q == QDS_FRAME);
    shift_evt = sclk_rise && !csn_s && (state_q == QDS_FRAME);
    out_evt = sclk_fall && (state_q == QDS_FRAME);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sticky faults
  logic [CHANNELS-1:0] fault_now;
  logic [CHANNELS-1:0] fault_q;

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_fault
      logic on_fault;
      logic off_fault;
      assign on_fault = detect.short_supply[g] | detect.overcurrent[g];
      assign off_fault = detect.open_load[g] | detect.short_ground[g];
      assign fault_now[g] = driver_chan[g] ? on_fault : off_fault;
    end
  endgenerate

  // hold until captured and on to the next select rise
  // restart at select rise so faults seen after a frame report in the next one
  // set wins: an indication in the restart cycle is kept
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fault_q <= QDS_FAULT_RST;
    end else if (apply_evt) begin
      fault_q <= fault_now;
    end else begin
      fault_q <= fault_q | fault_now;
    end
  end

  assign fault_sticky = fault_q;

  ////////////////////////////////////////////////////////////////////////////////
  // shift register: sixteen bits so the previous first byte comes back
  logic [QDS_SHIFT_W-1:0] shift_q;
  logic sdo_q;

  // upper half holds the first byte of a sixteen-bit frame, the verification data
  // limitation: a frame shorter than four bits loads stale bits into the latch
  // capture at select fall
  // fault bit n reports channel n
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shift_q <= QDS_SHIFT_RST;
    end else if (capture_evt) begin
      shift_q <= {QDS_UPPER_FAULT, (fault_q | fault_now), shift_q[QDS_SHIFT_W-1 -: QDS_WORD_W]};
    end else if (shift_evt) begin
      shift_q <= {shift_q[QDS_SHIFT_W-2:0], sdi_s};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // serial output
  // the first bit stands from select fall, so the first shift clock fall shows bit 6
  // faults out while command in
  // faults first then previous first byte
  // change on sclk fall, bit 7 first
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sdo_q <= 1'b0;
    end else if (capture_evt) begin
      sdo_q <= QDS_UPPER_FAULT[3];
    end else if (out_evt) begin
      sdo_q <= shift_q[QDS_SHIFT_W-1];
    end
  end

  always_comb begin
    sdo_oe_n = csn_s | (state_q != QDS_FRAME);
    sdo_out = sdo_q;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // output latch
  logic [CHANNELS-1:0] latch_q;

  // last four bits on select rise
  // bits 3..0 to channels, upper ignored
  // all switch at the same rise
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      latch_q <= QDS_LATCH_RST;
    end else if (apply_evt) begin
      latch_q <= shift_q[QDS_CMD_LSB +: CHANNELS];
    end
  end

  assign cmd_latch = latch_q;

  ////////////////////////////////////////////////////////////////////////////////
  // drivers
  // no glitch filter: a direct input change reaches its driver after two clocks
  // or of latch and direct input
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_drive
      assign driver_chan[g] = latch_q[g] | dd2_q[g];
    end
  endgenerate

endmodule

// ### include/qds_pkg.sv
// package: constants and carrier types for the quad driver serial control block
package qds_pkg;
  localparam int QDS_CHANNELS = 4;
  localparam int QDS_WORD_W = 8;
  localparam int QDS_SHIFT_W = 16;
  localparam int QDS_CMD_LSB = 0;
  localparam logic [15:0] QDS_SHIFT_RST = 16'h0000;
  localparam logic [3:0] QDS_LATCH_RST = 4'h0;
  localparam logic [3:0] QDS_FAULT_RST = 4'h0;
  localparam logic [3:0] QDS_UPPER_FAULT = 4'h0;
  // link timing, for reference by the bench
  localparam real QDS_CLK_NS = 25.0;
  localparam real QDS_SCLK_MIN_PERIOD_NS = 250.0;
  localparam int QDS_SCLK_MIN_CYCLES = int'(QDS_SCLK_MIN_PERIOD_NS / QDS_CLK_NS);

  // serial pins as seen by the device
  typedef struct packed {
    logic sclk;
    logic sdi;
    logic chip_sel_n;
  } qds_link_in_t;

  // analog detector indications per channel
  typedef struct packed {
    logic [3:0] short_supply;
    logic [3:0] overcurrent;
    logic [3:0] open_load;
    logic [3:0] short_ground;
  } qds_detect_t;

  typedef enum logic [1:0] {
    QDS_IDLE = 2'b01,
    QDS_FRAME = 2'b10
  } qds_state_t;
endpackage

// ### verif/qds_host_model.sv
// host model: serial bus master sending command frames
`timescale 1ns/1ps
module qds_host_model (
  output logic sclk,
  output logic sdi,
  output logic cs_n,
  output logic sdi_en,
  input wire logic sdo
);
  initial begin
    sclk = 0;
    sdi = 0;
    cs_n = 1;
    sdi_en = 0;
  end
  ////////////////////////////////////////////////////////////
  // frame bit count
  task automatic xfer(input int n, input logic [15:0] tx, output logic [15:0] rx);
    rx = '0;
    cs_n = 0;
    #300;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = tx[i];
      sdi_en = 1;
      #100 sclk = 1;
      #95;
      rx[i] = sdo;
      #5 sclk = 0;
    end
    // released data line falls to its pull-down
    #100 cs_n = 1;
    sdi_en = 0;
    #1000;
  endtask
endmodule

// ### verif/qds_core_checker.sv
// checker: port assertions for the quad driver serial block
`timescale 1ns/1ps
module qds_core_checker
  import qds_pkg::*;
#(
  parameter int CHANNELS = QDS_CHANNELS
) (
  input wire logic clk,
  input wire logic rstn,
  input wire qds_link_in_t link_in,
  input wire logic chip_sel_en,
  input wire qds_detect_t detect,
  input wire logic sdo_out,
  input wire logic sdo_oe_n,
  input wire logic [CHANNELS-1:0] driver_chan,
  input wire logic [CHANNELS-1:0] cmd_latch,
  input wire logic [CHANNELS-1:0] fault_sticky,
  input wire logic frame_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire cs_idle = link_in.chip_sel_n || !chip_sel_en;
  wire [CHANNELS-1:0] hit = ((detect.short_supply | detect.overcurrent) & driver_chan)
    | ((detect.open_load | detect.short_ground) & ~driver_chan);
  ////////////////////////////////////////////////////////////
  a_drive_or: assert property ((cmd_latch & ~driver_chan) == '0) else $error("latched channel off");
  a_frame_start: assert property ($fell(link_in.chip_sel_n) && chip_sel_en |-> ##[1:5] frame_active)
    else $error("frame not started");
  a_oe_idle: assert property (cs_idle [*6] |-> sdo_oe_n) else $error("sdo driven while idle");
  a_latch_frame: assert property ($changed(cmd_latch) |-> !frame_active) else $error("latch moved in frame");
  a_sdo_idle: assert property (!frame_active && !$past(frame_active) |-> $stable(sdo_out))
    else $error("sdo moved while idle");
  a_sdo_fall: assert property ($changed(sdo_out) && $past(frame_active) |-> !$past(link_in.sclk, 2))
    else $error("sdo moved off falling edge");
  a_first_bit: assert property ($rose(frame_active) |-> !sdo_out) else $error("bit 7 not zero");
  a_fault_class: assert property ((fault_sticky & ~$past(fault_sticky) & ~$past(hit)) == '0)
    else $error("fault set without cause");
  c_frame: cover property ($rose(frame_active));
  c_latch: cover property ($changed(cmd_latch));
  c_fault: cover property (fault_sticky != '0);
endmodule
bind qds_core qds_core_checker #(.CHANNELS(CHANNELS)) u_qds_core_checker (.clk(clk), .rstn(rstn),
  .link_in(link_in), .chip_sel_en(chip_sel_en), .detect(detect), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n),
  .driver_chan(driver_chan), .cmd_latch(cmd_latch), .fault_sticky(fault_sticky), .frame_active(frame_active));

// ### verif/qds_core_test.sv
// testbench: host frames, direct drive and fault capture
`timescale 1ns/1ps
module qds_core_test
  import qds_pkg::*;
;
  logic clk = 0, rstn = 0, chip_sel_en = 1;
  logic [3:0] direct_drive = 4'h0, direct_drive_en = 4'h0;
  qds_detect_t detect = '0;
  logic sclk, sdi, cs_n, sdi_en, sdo_out, sdo_oe_n, frame_active;
  logic [3:0] driver_chan, cmd_latch, fault_sticky;
  logic [15:0] rx;
  int num_errors = 0, compares = 0;
  initial forever #12.5 clk = ~clk;
  qds_host_model u_qds_host_model (.sclk(sclk), .sdi(sdi), .cs_n(cs_n), .sdi_en(sdi_en),
    .sdo(sdo_oe_n ? ~sdo_out : sdo_out));
  qds_core u_qds_core (.clk(clk), .rstn(rstn), .link_in(qds_link_in_t'({sclk, sdi, cs_n})),
    .direct_drive(direct_drive), .direct_drive_en(direct_drive_en), .sdi_en(sdi_en), .chip_sel_en(chip_sel_en),
    .detect(detect), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .driver_chan(driver_chan), .cmd_latch(cmd_latch),
    .fault_sticky(fault_sticky), .frame_active(frame_active));
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic send(input int n, input logic [15:0] tx);
    @(negedge clk);
    u_qds_host_model.xfer(n, tx, rx);
    repeat (10) @(negedge clk);
  endtask
  task automatic stop_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge clk);
    rstn = 1;
    repeat (4) @(negedge clk);
    chk({sdo_oe_n, fault_sticky, cmd_latch, driver_chan}, 13'h1000);
    send(8, 16'h00F5);
    chk({rx[7:0], cmd_latch}, 12'h005);
    // ch0 and ch2 on: only on-faults there, off-faults elsewhere count
    detect.short_supply = 4'h3;
    detect.open_load = 4'hC;
    @(negedge clk);
    detect = '0;
    repeat (2) @(negedge clk);
    chk(fault_sticky, 4'h9);
    send(8, 16'h000A);
    chk({rx[7:0], cmd_latch, fault_sticky}, 16'h09A0);
    direct_drive = 4'h5;
    direct_drive_en = 4'hF;
    repeat (4) @(negedge clk);
    chk(driver_chan, 4'hF);
    direct_drive_en = 4'h4;
    repeat (4) @(negedge clk);
    chk(driver_chan, 4'hE);
    direct_drive_en = 4'h0;
    send(16, 16'hC396);
    chk(cmd_latch, 4'h6);
    send(16, 16'h0000);
    chk(rx, 16'h00C3);
    chip_sel_en = 0;
    send(8, 16'h000F);
    chk({sdo_oe_n, cmd_latch}, 5'h10);
    stop_test();
  end
  initial begin
    #200us;
    num_errors++;
    $display("BAD %0t timeout", $time);
    stop_test();
  end
endmodule
